// >>> src/cmfd_pkg.sv
// shared constants and types of the chip mode and fast detect register bank
package cmfd_pkg;
    // register indices; byte address is four times the index
    localparam logic [31:0] CMFD_IDX_MODE  = 32'h0000_0200;
    localparam logic [31:0] CMFD_IDX_DECIM = 32'h0000_0201;
    localparam logic [31:0] CMFD_IDX_FDCTL = 32'h0000_0245;
    localparam logic [31:0] CMFD_IDX_CHSEL = 32'h0000_0010;
    localparam logic [31:0] CMFD_ADDR_MODE  = CMFD_IDX_MODE << 2;
    localparam logic [31:0] CMFD_ADDR_DECIM = CMFD_IDX_DECIM << 2;
    localparam logic [31:0] CMFD_ADDR_FDCTL = CMFD_IDX_FDCTL << 2;
    localparam logic [31:0] CMFD_ADDR_CHSEL = CMFD_IDX_CHSEL << 2;
    // writable bits and reset values
    localparam logic [7:0]  CMFD_MASK_MODE  = 8'hEF;
    localparam logic [7:0]  CMFD_MASK_DECIM = 8'h0F;
    localparam logic [7:0]  CMFD_MASK_FDCTL = 8'h0D;
    localparam logic [7:0]  CMFD_MASK_CHSEL = 8'h03;
    localparam logic [7:0]  CMFD_RST_MODE   = 8'h00;
    localparam logic [7:0]  CMFD_RST_DECIM  = 8'h00;
    localparam logic [7:0]  CMFD_RST_FDCTL  = 8'h00;
    localparam logic [7:0]  CMFD_RST_CHSEL  = 8'h03;
    // field positions
    localparam int          CMFD_BIT_QIGN   = 5;
    localparam int          CMFD_APP_LSB    = 0;
    localparam int          CMFD_DEC_LSB    = 0;
    localparam int          CMFD_BIT_FORCE  = 3;
    localparam int          CMFD_BIT_LEVEL  = 2;
    localparam int          CMFD_BIT_FDEN   = 0;
    // application mode, decimation bypass and transfer type codes
    localparam logic [3:0]  CMFD_APP_FULL   = 4'h0;
    localparam logic [3:0]  CMFD_APP_ONE    = 4'h1;
    localparam logic [3:0]  CMFD_APP_TWO    = 4'h2;
    localparam logic [3:0]  CMFD_APP_FOUR   = 4'h3;
    localparam logic [3:0]  CMFD_DEC_BYPASS = 4'h0;
    localparam logic [1:0]  CMFD_HTRANS_NSQ = 2'h2;

    typedef enum logic [1:0] {
        CMFD_ST_IDLE = 2'b01,
        CMFD_ST_WR   = 2'b10
    } cmfd_state_type;

    // decoded operating configuration
    typedef struct packed {
        logic       real_only;
        logic [3:0] ddc_enable;
        logic       bypass;
        logic [5:0] decim_factor;
    } cmfd_cfg_type;
endpackage

// >>> src/cmfd_regs.sv
// chip mode, decimation and fast detect pin control register bank, ahb-lite slave
//
// Function
// RULE1: q ignore bit 5 keeps only in-phase
// RULE2: app mode codes select ddc set
// RULE3: decimation code table, 0000 bypasses ddcs
// RULE4: force bit 3 overrides fast detect pin
// RULE5: forced pin takes level from bit 2
// RULE6: bit 0 clear, no force: pin low
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps

module cmfd_regs
    import cmfd_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    // clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 arst_n_i,
    // ahb-lite slave
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    output logic [31:0]               hrdata_o,
    // raw detector decisions per channel
    input  wire logic [NUM_CH-1:0]    detect_i,
    // fast detect pins
    output logic                      overrange_flag_pin_a_o,
    output logic                      overrange_flag_pin_b_o,
    // decoded configuration
    output cmfd_cfg_type              cfg_o,
    output logic                      downconverter_zero_o,
    output logic                      downconverter_one_o
);

    // reset synchroniser
    logic                 rst_meta;
    logic                 rst_n;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // decimation code to factor
    function automatic logic [5:0] dec_factor(input logic [3:0] code);
        case (code)
            4'h0:    dec_factor = 6'h01;
            4'h1:    dec_factor = 6'h02;
            4'h8:    dec_factor = 6'h03;
            4'h2:    dec_factor = 6'h04;
            4'h5:    dec_factor = 6'h05;
            4'h9:    dec_factor = 6'h06;
            4'h3:    dec_factor = 6'h08;
            4'h6:    dec_factor = 6'h0A;
            4'hA:    dec_factor = 6'h0C;
            4'h7:    dec_factor = 6'h0F;
            4'h4:    dec_factor = 6'h10;
            4'hD:    dec_factor = 6'h14;
            4'hB:    dec_factor = 6'h18;
            4'hE:    dec_factor = 6'h1E;
            4'hF:    dec_factor = 6'h28;
            4'hC:    dec_factor = 6'h30;
            default: dec_factor = 6'h01;
        endcase
    endfunction

    // application mode to downconverter set
    function automatic logic [3:0] app_ddc(input logic [3:0] code);
        case (code)
            CMFD_APP_FULL: app_ddc = 4'h0;
            CMFD_APP_ONE:  app_ddc = 4'h1;
            CMFD_APP_TWO:  app_ddc = 4'h3;
            CMFD_APP_FOUR: app_ddc = 4'hF;
            // undefined codes fall back to full bandwidth
            default:       app_ddc = 4'h0;
        endcase
    endfunction

    // bus state
    cmfd_state_type       state;
    cmfd_state_type       next_state;
    logic [31:0]          wr_addr;
    logic [31:0]          next_rdata;

    // register storage
    logic [7:0]           mode;
    logic [7:0]           decim;
    logic [7:0]           chsel;
    logic [7:0]           fdctl [NUM_CH];
    logic [7:0]           next_mode;
    logic [7:0]           next_decim;
    logic [7:0]           next_chsel;
    logic [7:0]           next_fdctl [NUM_CH];
    logic [NUM_CH-1:0]    pins;
    logic [NUM_CH-1:0]    next_pins;
    cmfd_cfg_type         next_cfg;

    // address phase decode
    wire                  req;
    wire                  rd_req;
    wire                  wr_req;
    wire                  wr_live;
    wire                  wr_mode;
    wire                  wr_decim;
    wire                  wr_chsel;
    wire                  wr_fdctl;
    wire [7:0]            wbyte;
    wire [7:0]            fd_rd;

    assign req      = hsel_i && hready_i && (htrans_i == CMFD_HTRANS_NSQ);
    assign rd_req   = req && !hwrite_i;
    assign wr_req   = req && hwrite_i;
    assign wr_live  = (state == CMFD_ST_WR);
    assign wbyte    = hwdata_i[7:0];
    assign wr_mode  = wr_live && (wr_addr == CMFD_ADDR_MODE);
    assign wr_decim = wr_live && (wr_addr == CMFD_ADDR_DECIM);
    assign wr_chsel = wr_live && (wr_addr == CMFD_ADDR_CHSEL);
    assign wr_fdctl = wr_live && (wr_addr == CMFD_ADDR_FDCTL);

    assign next_state = wr_req ? CMFD_ST_WR : CMFD_ST_IDLE;

    // write data is taken in its data phase; reserved bits stay masked
    assign next_mode  = wr_mode  ? (wbyte & CMFD_MASK_MODE)  : mode;
    assign next_decim = wr_decim ? (wbyte & CMFD_MASK_DECIM) : decim;
    assign next_chsel = wr_chsel ? (wbyte & CMFD_MASK_CHSEL) : chsel;

    // per channel fast detect control and pin
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            wire hit;
            wire force_en;
            wire level;
            wire det_en;
            assign hit      = wr_fdctl && chsel[ch];
            assign next_fdctl[ch] = hit ? (wbyte & CMFD_MASK_FDCTL) : fdctl[ch];
            assign force_en = fdctl[ch][CMFD_BIT_FORCE];
            assign level    = fdctl[ch][CMFD_BIT_LEVEL];
            assign det_en   = fdctl[ch][CMFD_BIT_FDEN];
            // force overrides the detector; disabled output rests low
            assign next_pins[ch] = force_en ? level :        // RULE4 RULE5
                                   (det_en & detect_i[ch]);  // RULE6
        end
    endgenerate

    // one process owns the whole array so no element has two drivers
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                fdctl[i] <= CMFD_RST_FDCTL;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                fdctl[i] <= next_fdctl[i];
            end
        end
    end

    // readback of the lowest selected channel, zero if none selected
    function automatic logic [7:0] pick_fd(input logic [7:0] sel,
                                           input logic [7:0] regs [NUM_CH]);
        logic [7:0] val;
        val = 8'h00;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (sel[i]) begin
                val = regs[i];
            end
        end
        return val;
    endfunction

    // read uses next values so a read right behind a write sees it
    assign fd_rd = pick_fd(next_chsel, next_fdctl);
    assign next_rdata =
        !rd_req                        ? 32'h0000_0000 :
        (haddr_i == CMFD_ADDR_MODE)    ? {24'h00_0000, next_mode}  :
        (haddr_i == CMFD_ADDR_DECIM)   ? {24'h00_0000, next_decim} :
        (haddr_i == CMFD_ADDR_CHSEL)   ? {24'h00_0000, next_chsel} :
        (haddr_i == CMFD_ADDR_FDCTL)   ? {24'h00_0000, fd_rd}      :
                                         32'h0000_0000;

    // decoded configuration
    assign next_cfg.real_only    = mode[CMFD_BIT_QIGN];                    // RULE1
    assign next_cfg.ddc_enable   = app_ddc(mode[CMFD_APP_LSB +: 4]);       // RULE2
    assign next_cfg.bypass       = (decim[CMFD_DEC_LSB +: 4] == CMFD_DEC_BYPASS); // RULE3
    assign next_cfg.decim_factor = dec_factor(decim[CMFD_DEC_LSB +: 4]);   // RULE3

    // bus side flops; zero wait states, always okay
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state       <= CMFD_ST_IDLE;
            wr_addr     <= 32'h0000_0000;
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b0;
            hresp_o     <= 1'b0;
        end else begin
            state       <= next_state;
            hrdata_o    <= next_rdata;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            if (wr_req) begin
                wr_addr <= haddr_i;
            end
        end
    end

    // register and output flops
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            mode  <= CMFD_RST_MODE;
            decim <= CMFD_RST_DECIM;
            chsel <= CMFD_RST_CHSEL;
            pins  <= '0;
            cfg_o <= '0;
            downconverter_zero_o <= 1'b0;
            downconverter_one_o  <= 1'b0;
        end else begin
            mode  <= next_mode;
            decim <= next_decim;
            chsel <= next_chsel;
            pins  <= next_pins;
            cfg_o <= next_cfg;
            downconverter_zero_o <= next_cfg.ddc_enable[0];  // RULE2
            downconverter_one_o  <= next_cfg.ddc_enable[1];  // RULE2
        end
    end

    // channel b absent when only one channel is built
    assign overrange_flag_pin_a_o = pins[0];
    generate
        if (NUM_CH > 1) begin : g_pin_b
            assign overrange_flag_pin_b_o = pins[1];
        end else begin : g_no_b
            assign overrange_flag_pin_b_o = 1'b0;
        end
    endgenerate

    // hsize is not checked: only whole-word transfers are expected
    wire unused_size;
    assign unused_size = ^hsize_i;

endmodule // cmfd_regs

// >>> verif/cmfd_regs_properties.sv
// concurrent checks on the ports of the register bank
`timescale 1ns/1ps
module cmfd_regs_properties
    import cmfd_pkg::*;
#(parameter int NUM_CH = 2) (
    // clock, reset and bus
    input wire logic              clock_i,
    input wire logic              arst_n_i,
    input wire logic              hsel_i,
    input wire logic [31:0]       haddr_i,
    input wire logic [1:0]        htrans_i,
    input wire logic              hwrite_i,
    input wire logic              hready_i,
    input wire logic [31:0]       hwdata_i,
    input wire logic [NUM_CH-1:0] detect_i,
    // watched outputs
    input wire logic              overrange_flag_pin_a_o,
    input wire logic              overrange_flag_pin_b_o,
    input wire cmfd_cfg_type      cfg_o,
    input wire logic              downconverter_zero_o,
    input wire logic              downconverter_one_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // mirror assumes every channel selected, as after reset
    logic       fd_wr;
    logic [7:0] fd_q;
    wire logic  norm_a = fd_q[0] & detect_i[0];
    wire logic  norm_b = fd_q[0] & detect_i[1];
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fd_wr <= 1'b0;
            fd_q  <= 8'h00;
        end else begin
            fd_wr <= hsel_i && hready_i && htrans_i == CMFD_HTRANS_NSQ && hwrite_i
                     && haddr_i == CMFD_ADDR_FDCTL;
            if (fd_wr) fd_q <= hwdata_i[7:0] & CMFD_MASK_FDCTL;
        end
    end
    function automatic logic [3:0] ddc_of(input logic [3:0] c);
        return (c == 4'h1) ? 4'h1 : (c == 4'h2) ? 4'h3 : (c == 4'h3) ? 4'hF : 4'h0;
    endfunction
    sequence s_wr(logic [31:0] a);
        hsel_i && hready_i && htrans_i == CMFD_HTRANS_NSQ && hwrite_i && haddr_i == a ##1 1'b1;
    endsequence
    property p_real_only;
        s_wr(CMFD_ADDR_MODE) |-> ##2 cfg_o.real_only == $past(hwdata_i[5], 2);
    endproperty
    property p_app;
        s_wr(CMFD_ADDR_MODE) |-> ##2 cfg_o.ddc_enable == ddc_of($past(hwdata_i[3:0], 2));
    endproperty
    property p_ddc_pins;
        downconverter_zero_o == cfg_o.ddc_enable[0] && downconverter_one_o == cfg_o.ddc_enable[1];
    endproperty
    property p_bypass;
        s_wr(CMFD_ADDR_DECIM) |-> ##2 cfg_o.bypass == ($past(hwdata_i[3:0], 2) == 4'h0);
    endproperty
    property p_bypass_fac;
        cfg_o.bypass |-> cfg_o.decim_factor == 6'h01;
    endproperty
    property p_force;
        fd_q[3] |=> overrange_flag_pin_a_o == $past(fd_q[2])
                    && overrange_flag_pin_b_o == $past(fd_q[2]);
    endproperty
    property p_norm;
        !fd_q[3] |=> overrange_flag_pin_a_o == $past(norm_a)
                     && overrange_flag_pin_b_o == $past(norm_b);
    endproperty
    property p_off;
        !fd_q[3] && !fd_q[0] |=> !overrange_flag_pin_a_o && !overrange_flag_pin_b_o;
    endproperty
    a_real_only: assert property (p_real_only) else $error("real only wrong");
    a_app: assert property (p_app) else $error("ddc set wrong");
    a_ddc_pins: assert property (p_ddc_pins) else $error("ddc pins wrong");
    a_bypass: assert property (p_bypass) else $error("bypass wrong");
    a_bypass_fac: assert property (p_bypass_fac) else $error("bypass factor wrong");
    a_force: assert property (p_force) else $error("forced pin wrong");
    a_norm: assert property (p_norm) else $error("normal pin wrong");
    a_off: assert property (p_off) else $error("disabled pin not low");
endmodule // cmfd_regs_properties

// >>> verif/cmfd_regs_tb_top.sv
// self-checking bench of the register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module cmfd_regs_tb_top;
    import cmfd_pkg::*;
    logic clock_i, arst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, pa, pb, dz, d1;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    logic [1:0]  htrans_i, detect_i;
    cmfd_cfg_type cfg_o;
    int n_errors = 0;
    int n_checks = 0;
    logic [3:0] ddc_t [5] = '{4'h0, 4'h1, 4'h3, 4'hF, 4'h0};
    logic [5:0] fac_t [16] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h05, 6'h0A, 6'h0F,
                               6'h03, 6'h06, 6'h0C, 6'h18, 6'h30, 6'h14, 6'h1E, 6'h28};
    logic [9:0] pin_t [7] = '{{8'h08, 2'h3}, {8'h0C, 2'h0}, {8'hFF, 2'h0}, {8'h01, 2'h1},
                              {8'h01, 2'h2}, {8'h00, 2'h3}, {8'h05, 2'h3}};
    logic [1:0] pin_e [7] = '{2'h0, 2'h3, 2'h3, 2'h1, 2'h2, 2'h0, 2'h3};
    cmfd_regs dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .hrdata_o(hrdata_o), .detect_i(detect_i),
        .overrange_flag_pin_a_o(pa), .overrange_flag_pin_b_o(pb), .cfg_o(cfg_o),
        .downconverter_zero_o(dz), .downconverter_one_o(d1));
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= CMFD_HTRANS_NSQ;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
        `CHK("hresp", 1'b0, hresp_o)
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK("read data", e, rd)
    endtask
    // outputs are registered behind the register, one edge later
    task automatic settle();
        @(posedge clock_i);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    initial begin
        repeat (5000) @(posedge clock_i);
        n_errors++;
        wrap_up();
    end
    initial begin
        {arst_n_i, hsel_i, hwrite_i, htrans_i, detect_i} = '0;
        {haddr_i, hwdata_i} = '0;
        repeat (12) @(posedge clock_i);
        arst_n_i <= 1'b1;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        rdchk(CMFD_ADDR_MODE, 32'h0);
        rdchk(CMFD_ADDR_DECIM, 32'h0);
        rdchk(CMFD_ADDR_FDCTL, 32'h0);
        rdchk(CMFD_ADDR_CHSEL, 32'h3);
        `CHK("cfg reset", 12'h041, cfg_o)
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, CMFD_ADDR_MODE, {24'h0, 2'b10, i[0], 1'b1, (i == 4) ? 4'h5 : i[3:0]});
            settle();
            `CHK("ddc set", ddc_t[i], cfg_o.ddc_enable)
            `CHK("ddc pins", ddc_t[i][1:0], {d1, dz})
            `CHK("real only", i[0], cfg_o.real_only)
            rdchk(CMFD_ADDR_MODE, {24'h0, 2'b10, i[0], 1'b0, (i == 4) ? 4'h5 : i[3:0]});
        end
        $display("test mode codes done");
        for (int c = 0; c < 16; c++) begin
            xfer(1'b1, CMFD_ADDR_DECIM, {24'h0, 4'hF, c[3:0]});
            settle();
            `CHK("factor", fac_t[c], cfg_o.decim_factor)
            `CHK("bypass", c == 0, cfg_o.bypass)
            rdchk(CMFD_ADDR_DECIM, {28'h0, c[3:0]});
        end
        $display("test decimation table done");
        for (int k = 0; k < 7; k++) begin
            detect_i <= pin_t[k][1:0];
            xfer(1'b1, CMFD_ADDR_FDCTL, {24'h0, pin_t[k][9:2]});
            settle();
            `CHK("fast detect pins", pin_e[k], {pb, pa})
            rdchk(CMFD_ADDR_FDCTL, {24'h0, pin_t[k][9:2] & CMFD_MASK_FDCTL});
        end
        $display("test fast detect pins done");
        xfer(1'b1, 32'h0000_0100, 32'hFF);
        rdchk(32'h0000_0100, 32'h0);
        rdchk(CMFD_ADDR_FDCTL, 32'h5);
        $display("test unmapped address done");
        wrap_up();
    end
endmodule // cmfd_regs_tb_top
bind cmfd_regs cmfd_regs_properties #(.NUM_CH(NUM_CH)) prop_u (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i), .detect_i(detect_i),
    .overrange_flag_pin_a_o(overrange_flag_pin_a_o),
    .overrange_flag_pin_b_o(overrange_flag_pin_b_o), .cfg_o(cfg_o),
    .downconverter_zero_o(downconverter_zero_o), .downconverter_one_o(downconverter_one_o));
